// File: hw/ddr_cmd_sched.sv
// Host-side DDR command scheduler enforcing device command timing
`timescale 1ns/10ps
module ddr_cmd_sched import ddr_timing_pkg::*; #(
    parameter int RAS_MAX_S = RAS_MAX_S_CYC,
    parameter int REFI = REFI_CYC_DEF,
    parameter int REFI_HOT = REFI_HOT_CYC_DEF
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic slow_grade,
    input wire logic extended_temp_automotive_grade,
    input wire logic req_valid,
    input wire cmd_t req_cmd,
    input wire logic [1:0] req_bank,
    input wire logic [12:0] req_addr,
    output logic req_ack,
    output logic refresh_due,
    output logic in_self_refresh,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [1:0] ba,
    output logic [12:0] addr,
    output logic cke,
    output logic dqs_out,
    output logic dqs_oe_n,
    output logic dqs_post
);
    // Short counts are all well below 256 cycles at this clock
    function automatic logic [7:0] pick(logic s, int f, int sl);
        return s ? 8'(sl) : 8'(f);
    endfunction

    function automatic logic [7:0] dec(logic [7:0] v);
        return (v == 8'h0) ? 8'h0 : v - 8'h1;
    endfunction

    strobe_if sif ();
    wr_strobe_seq u_seq (.core_clk(core_clk), .rst(rst), .sif(sif.seq));

    logic [7:0] t_rcd, t_ras, t_rfc, t_rrd, t_rp, t_rap;
    logic [12:0] ras_lim;
    logic [18:0] refi_lim;
    always_comb begin
        t_rcd = pick(slow_grade, RCD_F_CYC, RCD_S_CYC);
        t_ras = pick(slow_grade, RAS_F_CYC, RAS_S_CYC);
        t_rfc = pick(slow_grade, RFC_F_CYC, RFC_S_CYC);
        t_rrd = pick(slow_grade, RRD_F_CYC, RRD_S_CYC);
        t_rp = pick(slow_grade, RP_F_CYC, RP_S_CYC);
        t_rap = pick(slow_grade, RAP_F_CYC, RAP_S_CYC);
        ras_lim = slow_grade ? 13'(RAS_MAX_S - RAS_GUARD)
                             : 13'(RAS_MAX_F_CYC - RAS_GUARD);
        refi_lim = extended_temp_automotive_grade ? 19'(REFI_HOT - 1)
                                                  : 19'(REFI - 1);
    end

    logic [BANKS-1:0] open, next_open;
    logic [7:0] c_rcd [BANKS], next_c_rcd [BANKS];
    logic [7:0] c_ras [BANKS], next_c_ras [BANKS];
    logic [7:0] c_rc [BANKS], next_c_rc [BANKS];
    logic [7:0] c_wr [BANKS], next_c_wr [BANKS];
    logic [7:0] c_rap [BANKS], next_c_rap [BANKS];
    logic [12:0] c_open [BANKS], next_c_open [BANKS];
    logic [7:0] c_rfc, c_rrd, c_wtr, c_mrd, c_xsnr, c_xsrd;
    logic [7:0] next_c_rfc, next_c_rrd, next_c_wtr, next_c_mrd;
    logic [7:0] next_c_xsnr, next_c_xsrd;
    logic [18:0] c_refi, next_c_refi;
    logic [3:0] pending, next_pending;
    logic sr, next_sr;
    logic next_req_ack, next_start;
    logic [3:0] next_pins;
    logic [1:0] next_ba;
    logic [12:0] next_addr;
    logic next_cke;

    cmd_t cmd;
    logic [1:0] cb;
    logic quiet, all_idle, ref_ok, ok, urgent, force_pre;
    logic [1:0] force_bank;

    always_comb begin
        quiet = (c_mrd == 8'h0) && (c_xsnr == 8'h0) && !sr;
        all_idle = (open == '0) && (c_rfc == 8'h0);
        for (int i = 0; i < BANKS; i++) begin
            all_idle = all_idle && (c_rc[i] == 8'h0);
        end
        ref_ok = quiet && all_idle;
        urgent = (pending >= 4'(REF_POST_MAX - 1));
        force_pre = 1'b0;
        force_bank = 2'h0;
        // Expiring rows take first place, then refresh backlog
        for (int i = BANKS - 1; i >= 0; i--) begin
            if (open[i] && c_ras[i] == 8'h0 && c_wr[i] == 8'h0 && quiet
                && (c_open[i] >= ras_lim || urgent)) begin
                force_pre = 1'b1;
                force_bank = 2'(i);
            end
        end
        if (force_pre) begin
            cmd = CMD_PRE;
            cb = force_bank;
        end else if (urgent && ref_ok) begin
            cmd = CMD_REF;
            cb = 2'h0;
        end else if (req_valid && !(urgent && req_cmd != CMD_REF
                                   && req_cmd != CMD_PRE)) begin
            cmd = req_cmd;
            cb = req_bank;
        end else begin
            cmd = CMD_NOP;
            cb = 2'h0;
        end
        case (cmd)
            CMD_ACT: ok = quiet && !open[cb] && c_rc[cb] == 8'h0
                && c_rrd == 8'h0 && c_rfc == 8'h0;
            CMD_RD, CMD_RDA: ok = quiet && open[cb] && c_rcd[cb] == 8'h0
                && c_wtr == 8'h0 && !sif.busy && c_xsrd == 8'h0
                && !sif.done && !sif.start
                && (cmd == CMD_RD || c_rap[cb] == 8'h0);
            CMD_WR, CMD_WRA: ok = quiet && open[cb] && c_rcd[cb] == 8'h0
                && !sif.busy && !sif.start;
            CMD_PRE: ok = quiet && (!open[cb] || (c_ras[cb] == 8'h0
                && c_wr[cb] == 8'h0));
            CMD_REF, CMD_MRS, CMD_SRE: ok = ref_ok;
            CMD_SRX: ok = sr;
            default: ok = 1'b0;
        endcase
    end

    always_comb begin
        next_open = open;
        next_c_rcd = c_rcd;
        next_c_ras = c_ras;
        next_c_rc = c_rc;
        next_c_wr = c_wr;
        next_c_rap = c_rap;
        next_c_open = c_open;
        for (int i = 0; i < BANKS; i++) begin
            next_c_rcd[i] = dec(c_rcd[i]);
            next_c_ras[i] = dec(c_ras[i]);
            next_c_rc[i] = dec(c_rc[i]);
            next_c_wr[i] = dec(c_wr[i]);
            next_c_rap[i] = dec(c_rap[i]);
            next_c_open[i] = open[i] ? c_open[i] + 13'h1 : 13'h0;
        end
        next_c_rfc = dec(c_rfc);
        next_c_rrd = dec(c_rrd);
        next_c_wtr = sif.done ? 8'(WTR_CYC) : dec(c_wtr);
        next_c_mrd = dec(c_mrd);
        next_c_xsnr = dec(c_xsnr);
        next_c_xsrd = dec(c_xsrd);
        next_sr = sr;
        next_pending = pending;
        next_req_ack = 1'b0;
        next_start = 1'b0;
        next_pins = 4'h7;
        next_ba = 2'h0;
        next_addr = addr;
        next_cke = !sr;
        // Self refresh keeps the array alive, so the interval timer rests
        next_c_refi = sr ? c_refi : (c_refi >= refi_lim) ? 19'h0
                                                          : c_refi + 19'h1;
        if (!sr && c_refi >= refi_lim && pending != 4'(REF_POST_MAX)) begin
            next_pending = pending + 4'h1;
        end
        if (ok) begin
            next_req_ack = !(force_pre || (urgent && cmd == CMD_REF
                             && !(req_valid && req_cmd == CMD_REF)));
            next_ba = cb;
            next_addr = req_addr;
            case (cmd)
                CMD_ACT: begin
                    next_pins = 4'h3;
                    next_open[cb] = 1'b1;
                    next_c_rcd[cb] = t_rcd - 8'h1;
                    next_c_ras[cb] = t_ras - 8'h1;
                    next_c_rc[cb] = 8'(RC_CYC - 1);
                    next_c_rap[cb] = t_rap - 8'h1;
                    next_c_rrd = t_rrd - 8'h1;
                end
                CMD_RD, CMD_RDA: begin
                    next_pins = 4'h5;
                    next_addr[10] = (cmd == CMD_RDA);
                    if (cmd == CMD_RDA) begin
                        next_open[cb] = 1'b0;
                        next_c_rc[cb] = 8'(BEATS / 2) + t_rp;
                    end
                end
                CMD_WR, CMD_WRA: begin
                    next_pins = 4'h4;
                    next_start = 1'b1;
                    next_addr[10] = (cmd == CMD_WRA);
                    next_c_wr[cb] = 8'(DQSS_CYC + BEATS + WR_CYC);
                    if (cmd == CMD_WRA) begin
                        next_open[cb] = 1'b0;
                        next_c_rc[cb] = 8'(DQSS_CYC + BEATS + WR_CYC)
                                        + t_rp;
                    end
                end
                CMD_PRE: begin
                    next_pins = 4'h2;
                    next_addr[10] = 1'b0;
                    next_open[cb] = 1'b0;
                    if (open[cb]) begin
                        next_c_rc[cb] = (c_rc[cb] > t_rp) ? dec(c_rc[cb])
                                                          : t_rp - 8'h1;
                    end
                end
                CMD_REF: begin
                    next_pins = 4'h1;
                    next_c_rfc = t_rfc - 8'h1;
                    if (pending != 4'h0 && !(c_refi >= refi_lim)) begin
                        next_pending = pending - 4'h1;
                    end else if (pending == 4'h0 || c_refi >= refi_lim) begin
                        next_pending = (c_refi >= refi_lim) ? pending
                                                            : 4'h0;
                    end
                end
                CMD_MRS: begin
                    next_pins = 4'h0;
                    next_c_mrd = 8'(MRD_CYC - 1);
                end
                CMD_SRE: begin
                    next_pins = 4'h1;
                    next_cke = 1'b0;
                    next_sr = 1'b1;
                end
                CMD_SRX: begin
                    next_cke = 1'b1;
                    next_sr = 1'b0;
                    next_c_xsnr = 8'(XSNR_CYC);
                    next_c_xsrd = 8'(XSRD_CYC);
                end
                default: next_pins = 4'h7;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            open <= '0;
            for (int i = 0; i < BANKS; i++) begin
                c_rcd[i] <= 8'h0;
                c_ras[i] <= 8'h0;
                c_rc[i] <= 8'h0;
                c_wr[i] <= 8'h0;
                c_rap[i] <= 8'h0;
                c_open[i] <= 13'h0;
            end
            c_rfc <= 8'h0;
            c_rrd <= 8'h0;
            c_wtr <= 8'h0;
            c_mrd <= 8'h0;
            c_xsnr <= 8'h0;
            c_xsrd <= 8'h0;
            c_refi <= 19'h0;
            pending <= 4'h0;
            refresh_due <= 1'b0;
            sr <= 1'b0;
            req_ack <= 1'b0;
            sif.start <= 1'b0;
            {cs_n, ras_n, cas_n, we_n} <= 4'hf;
            ba <= 2'h0;
            addr <= 13'h0;
            cke <= 1'b0;
        end else begin
            open <= next_open;
            c_rcd <= next_c_rcd;
            c_ras <= next_c_ras;
            c_rc <= next_c_rc;
            c_wr <= next_c_wr;
            c_rap <= next_c_rap;
            c_open <= next_c_open;
            c_rfc <= next_c_rfc;
            c_rrd <= next_c_rrd;
            c_wtr <= next_c_wtr;
            c_mrd <= next_c_mrd;
            c_xsnr <= next_c_xsnr;
            c_xsrd <= next_c_xsrd;
            c_refi <= next_c_refi;
            pending <= next_pending;
            refresh_due <= (next_pending != 4'h0);
            sr <= next_sr;
            req_ack <= next_req_ack;
            sif.start <= next_start;
            {cs_n, ras_n, cas_n, we_n} <= {1'b0, next_pins[2:0]};
            ba <= next_ba;
            addr <= next_addr;
            cke <= next_cke;
        end
    end

    always_comb begin
        in_self_refresh = sr;
        dqs_out = sif.dqs;
        dqs_oe_n = sif.dqs_oe_n;
        dqs_post = sif.post;
    end

    logic pin_act, pin_ref, pin_rd, pin_mrs;
    logic [7:0] srx_age;
    always_comb begin
        pin_act = !cs_n && {ras_n, cas_n, we_n} == 3'h3;
        pin_ref = !cs_n && {ras_n, cas_n, we_n} == 3'h1;
        pin_rd = !cs_n && {ras_n, cas_n, we_n} == 3'h5;
        pin_mrs = !cs_n && {ras_n, cas_n, we_n} == 3'h0;
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            srx_age <= 8'hff;
        end else begin
            // Only a self refresh exit restarts the age, not reset release
            srx_age <= $fell(sr) ? 8'h0
                     : (srx_age == 8'hff) ? srx_age : srx_age + 8'h1;
        end
    end

    sequence no_act_s;
        !pin_act && !pin_ref;
    endsequence
    refresh_gap_a: assert property (@(posedge core_clk) disable iff (rst)
        pin_ref && cke |=> no_act_s [*2])
        else $error("activate or refresh too soon after refresh");
    act_same_bank_a: assert property (@(posedge core_clk) disable iff (rst)
        pin_act |=> !(pin_act && ba == $past(ba))
        ##1 !(pin_act && ba == $past(ba, 2)))
        else $error("same bank activated within row cycle");
    mrs_gap_a: assert property (@(posedge core_clk) disable iff (rst)
        pin_mrs |=> !(!cs_n && {ras_n, cas_n, we_n} != 3'h7))
        else $error("command issued too soon after mode register set");
    wtr_gap_a: assert property (@(posedge core_clk) disable iff (rst)
        sif.done |-> !pin_rd ##1 !pin_rd ##1 !pin_rd)
        else $error("read too soon after last write data");
    xsrd_gap_a: assert property (@(posedge core_clk) disable iff (rst)
        pin_rd |-> srx_age >= 8'(XSRD_CYC))
        else $error("read too soon after self refresh exit");
    xsnr_gap_a: assert property (@(posedge core_clk) disable iff (rst)
        (pin_act || pin_ref || pin_mrs) && cke |-> srx_age >= 8'(XSNR_CYC))
        else $error("command too soon after self refresh exit");
    backlog_cap_a: assert property (@(posedge core_clk) disable iff (rst)
        pending <= 4'(REF_POST_MAX))
        else $error("refresh backlog beyond limit");
    row_expire_a: assert property (@(posedge core_clk) disable iff (rst)
        open[0] |-> c_open[0] <= ras_lim + 13'h4)
        else $error("row open past maximum time");
    write_start_a: assert property (@(posedge core_clk) disable iff (rst)
        sif.start |-> !cs_n && {ras_n, cas_n, we_n} == 3'h4 ##2 !dqs_oe_n)
        else $error("write strobe not started with write");
endmodule

// File: hw/wr_strobe_seq.sv
// Write data strobe sequencer: preamble, burst toggles, postamble
`timescale 1ns/10ps
module wr_strobe_seq import ddr_timing_pkg::*; (
    input wire logic core_clk,
    input wire logic rst,
    strobe_if.seq sif
);
    strobe_state_t state, next_state;
    logic [2:0] beat, next_beat;
    logic dqs, next_dqs;
    logic oe_n, next_oe_n;
    logic post, next_post;
    logic done, next_done;

    always_comb begin
        next_state = state;
        next_beat = beat;
        next_dqs = 1'b0;
        next_oe_n = 1'b1;
        next_post = 1'b0;
        next_done = 1'b0;
        case (state)
            S_IDLE: begin
                if (sif.start) begin
                    // Low preamble a full cycle, first rise one cycle later
                    next_state = S_PRE;
                    next_oe_n = 1'b0;
                end
            end
            S_PRE: begin
                next_state = S_BURST;
                next_beat = 3'h1;
                next_dqs = 1'b1;
                next_oe_n = 1'b0;
            end
            S_BURST: begin
                next_oe_n = 1'b0;
                if (beat == 3'(BEATS)) begin
                    next_state = S_POST;
                    next_post = 1'b1;
                end else begin
                    next_beat = beat + 3'h1;
                    next_dqs = ~dqs;
                end
            end
            S_POST: begin
                next_state = S_IDLE;
                next_done = 1'b1;
            end
            default: next_state = S_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state <= S_IDLE;
            beat <= 3'h0;
            dqs <= 1'b0;
            oe_n <= 1'b1;
            post <= 1'b0;
            done <= 1'b0;
        end else begin
            state <= next_state;
            beat <= next_beat;
            dqs <= next_dqs;
            oe_n <= next_oe_n;
            post <= next_post;
            done <= next_done;
        end
    end

    assign sif.busy = (state != S_IDLE);
    assign sif.done = done;
    assign sif.dqs = dqs;
    assign sif.dqs_oe_n = oe_n;
    assign sif.post = post;

    sequence pre_low_s;
        !oe_n && !dqs;
    endsequence
    sequence first_rise_s;
        !oe_n && dqs;
    endsequence
    strobe_place_a: assert property (@(posedge core_clk) disable iff (rst)
        (state == S_IDLE && sif.start) |=> pre_low_s ##1 first_rise_s)
        else $error("strobe preamble or first rise misplaced");
    postamble_a: assert property (@(posedge core_clk) disable iff (rst)
        $rose(post) |-> !oe_n && !dqs ##1 oe_n && done)
        else $error("write postamble malformed");
endmodule

// File: include/ddr_timing_pkg.sv
// Timing constants, command set and helpers for the DDR command scheduler
package ddr_timing_pkg;
    localparam real CLK_NS = 25.0;

    function automatic int cyc_min(real ns);
        int c;
        c = int'($ceil(ns / CLK_NS));
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int cyc_max(real ns);
        int c;
        c = int'($floor(ns / CLK_NS));
        return (c < 1) ? 1 : c;
    endfunction

    localparam real T_RCD_F_NS = 15.0;
    localparam real T_RCD_S_NS = 18.0;
    localparam real T_RAS_F_NS = 40.0;
    localparam real T_RAS_S_NS = 42.0;
    localparam real T_RAS_MAX_F_NS = 70000.0;
    localparam real T_RAS_MAX_S_NS = 120000.0;
    localparam real T_RC_NS = 60.0;
    localparam real T_RFC_F_NS = 70.0;
    localparam real T_RFC_S_NS = 72.0;
    localparam real T_RRD_F_NS = 10.0;
    localparam real T_RRD_S_NS = 12.0;
    localparam real T_WR_NS = 15.0;
    localparam real T_RP_F_NS = 15.0;
    localparam real T_RP_S_NS = 18.0;
    localparam real T_RAP_F_NS = 0.5;
    localparam real T_RAP_S_NS = 18.0;
    localparam real T_XSNR_NS = 70.0;
    localparam real T_REFI_MS = 7.8;
    localparam real T_REFI_HOT_MS = 1.9;

    localparam int RCD_F_CYC = cyc_min(T_RCD_F_NS);
    localparam int RCD_S_CYC = cyc_min(T_RCD_S_NS);
    localparam int RAS_F_CYC = cyc_min(T_RAS_F_NS);
    localparam int RAS_S_CYC = cyc_min(T_RAS_S_NS);
    localparam int RAS_MAX_F_CYC = cyc_max(T_RAS_MAX_F_NS);
    localparam int RAS_MAX_S_CYC = cyc_max(T_RAS_MAX_S_NS);
    localparam int RC_CYC = cyc_min(T_RC_NS);
    localparam int RFC_F_CYC = cyc_min(T_RFC_F_NS);
    localparam int RFC_S_CYC = cyc_min(T_RFC_S_NS);
    localparam int RRD_F_CYC = cyc_min(T_RRD_F_NS);
    localparam int RRD_S_CYC = cyc_min(T_RRD_S_NS);
    localparam int WR_CYC = cyc_min(T_WR_NS);
    localparam int RP_F_CYC = cyc_min(T_RP_F_NS);
    localparam int RP_S_CYC = cyc_min(T_RP_S_NS);
    localparam int RAP_F_CYC = cyc_min(T_RAP_F_NS);
    localparam int RAP_S_CYC = cyc_min(T_RAP_S_NS);
    localparam int XSNR_CYC = cyc_min(T_XSNR_NS);
    localparam int REFI_CYC_DEF = cyc_max(T_REFI_MS * 1.0e6);
    localparam int REFI_HOT_CYC_DEF = cyc_max(T_REFI_HOT_MS * 1.0e6);
    localparam int WTR_CYC = 2;
    localparam int MRD_CYC = 2;
    localparam int XSRD_CYC = 200;
    localparam int REF_POST_MAX = 8;
    localparam int RAS_GUARD = 2;
    localparam int BEATS = 4;
    localparam int DQSS_CYC = 1;
    localparam int BANKS = 4;

    typedef enum logic [3:0] {
        CMD_NOP, CMD_ACT, CMD_RD, CMD_RDA, CMD_WR, CMD_WRA,
        CMD_PRE, CMD_REF, CMD_MRS, CMD_SRE, CMD_SRX
    } cmd_t;

    typedef enum logic [1:0] {S_IDLE, S_PRE, S_BURST, S_POST} strobe_state_t;
endpackage

// File: include/strobe_if.sv
// Write strobe hand-off between scheduler and strobe sequencer
`timescale 1ns/10ps
interface strobe_if;
    logic start;
    logic busy;
    logic done;
    logic dqs;
    logic dqs_oe_n;
    logic post;
    modport ctrl (output start, input busy, done, dqs, dqs_oe_n, post);
    modport seq (input start, output busy, done, dqs, dqs_oe_n, post);
endinterface

// File: verification/ddr_dev_model.sv
// Behavioural device model that counts command spacing faults
`timescale 1ns/10ps
module ddr_dev_model import ddr_timing_pkg::*; (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [3:0] pins,
    input wire logic [1:0] ba,
    input wire logic cke,
    output logic [7:0] viol
);
    int now;
    int act_at [BANKS];
    int ref_at;
    int mrs_at;
    int any_act;
    // Slow figures used: never below the fast ones
    always @(posedge core_clk) begin
        if (rst) begin
            now = 0;
            viol = 8'h00;
            ref_at = -999;
            mrs_at = -999;
            any_act = -999;
            foreach (act_at[i]) act_at[i] = -999;
        end else begin
            now = now + 1;
            if (cke && !pins[3] && pins[2:0] != 3'h7) begin
                if (now - mrs_at < MRD_CYC) viol = viol + 8'h01;
                if (pins == 4'h3) begin
                    if (now - act_at[ba] < RC_CYC) viol = viol + 8'h01;
                    if (now - any_act < RRD_S_CYC) viol = viol + 8'h01;
                    if (now - ref_at < RFC_S_CYC) viol = viol + 8'h01;
                    act_at[ba] = now;
                    any_act = now;
                end
                if (pins == 4'h1) begin
                    if (now - ref_at < RFC_S_CYC) viol = viol + 8'h01;
                    ref_at = now;
                end
                if (pins[3:1] == 3'h2 && now - act_at[ba] < RCD_S_CYC)
                    viol = viol + 8'h01;
                if (pins == 4'h0) mrs_at = now;
            end
        end
    end
endmodule

// File: verification/testbench.sv
// Self-checking bench for the DDR command scheduler
`timescale 1ns/10ps
module testbench import ddr_timing_pkg::*;;
    localparam int HOT_T = 30;
    logic core_clk = 0, rst = 1, slow_grade = 0, req_valid = 0;
    logic extended_temp_automotive_grade = 0;
    cmd_t req_cmd = CMD_NOP;
    logic [1:0] req_bank = 2'h0, ba;
    logic [12:0] req_addr = 13'h0000, addr;
    logic req_ack, refresh_due, in_self_refresh, cs_n, ras_n, cas_n, we_n;
    logic cke, dqs_out, dqs_oe_n, dqs_post;
    logic [3:0] pins;
    logic [7:0] viol;
    int errors = 0, n_compared = 0, cyc = 0, last = 0, gap, t0;
    assign pins = {cs_n, ras_n, cas_n, we_n};
    ddr_cmd_sched #(.RAS_MAX_S(60), .REFI(60), .REFI_HOT(HOT_T)) dut_u (
        .core_clk, .rst, .slow_grade, .extended_temp_automotive_grade,
        .req_valid, .req_cmd, .req_bank, .req_addr, .req_ack, .refresh_due,
        .in_self_refresh, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .cke,
        .dqs_out, .dqs_oe_n, .dqs_post);
    ddr_dev_model dev_u (.core_clk, .rst, .pins, .ba, .cke, .viol);
    initial forever #12.5 core_clk = ~core_clk;
    always @(posedge core_clk) cyc <= cyc + 1;
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Idle edge first so the strobe never changes twice in one step
    task automatic issue(cmd_t c, logic [1:0] b, logic [12:0] a);
        int n;
        @(negedge core_clk);
        req_cmd = c;
        req_bank = b;
        req_addr = a;
        req_valid = 1'b1;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (req_ack !== 1'b1 && n < 400);
        req_valid = 1'b0;
        if (n >= 400) check("ack", 1'b0, 1'b1);
        gap = cyc - last;
        last = cyc;
    endtask
    task automatic t_bank();
        issue(CMD_ACT, 2'h0, 13'h0000);
        check("act pins", pins, 4'h3);
        t0 = last;
        issue(CMD_ACT, 2'h1, 13'h0000);
        check("act ba", ba, 2'h1);
        check("rrd", gap >= RRD_F_CYC, 1'b1);
        issue(CMD_RD, 2'h0, 13'h0000);
        check("rd pins", pins, 4'h5);
        issue(CMD_PRE, 2'h0, 13'h0000);
        check("ras", last - t0 >= RAS_F_CYC, 1'b1);
        issue(CMD_ACT, 2'h0, 13'h0000);
        check("rc", last - t0 >= RC_CYC, 1'b1);
        issue(CMD_RDA, 2'h1, 13'h0400);
        check("rda ap", addr[10], 1'b1);
        issue(CMD_ACT, 2'h1, 13'h0000);
        check("rda act", gap >= BEATS / 2 + RP_F_CYC, 1'b1);
        issue(CMD_PRE, 2'h0, 13'h0000);
        issue(CMD_PRE, 2'h1, 13'h0000);
        $display("test bank done");
    endtask
    task automatic t_write();
        issue(CMD_ACT, 2'h3, 13'h0000);
        issue(CMD_WR, 2'h3, 13'h0000);
        check("wr pins", pins, 4'h4);
        for (int i = 0; i < 7; i++) begin
            @(negedge core_clk);
            check("dqs_oe_n", dqs_oe_n, i == 6);
            if (i < 6) check("dqs", dqs_out, i % 2 == 1 && i < 5);
            check("dqs_post", dqs_post, i == 5);
        end
        issue(CMD_RD, 2'h3, 13'h0000);
        check("wtr", gap >= BEATS + 1 + WTR_CYC, 1'b1);
        issue(CMD_WRA, 2'h3, 13'h0400);
        issue(CMD_ACT, 2'h3, 13'h0000);
        check("dal", gap >= BEATS + 1 + WR_CYC + RP_F_CYC, 1'b1);
        issue(CMD_PRE, 2'h3, 13'h0000);
        $display("test write done");
    endtask
    // Slow grade with a short maximum open time: row must be closed for us
    task automatic t_expire();
        int n;
        slow_grade = 1'b1;
        issue(CMD_ACT, 2'h0, 13'h0000);
        t0 = last;
        n = 0;
        while (pins !== 4'h2 && n < 100) begin
            @(negedge core_clk);
            n++;
        end
        check("forced pre", cyc - t0 <= 60, 1'b1);
        check("pre ba", ba, 2'h0);
        slow_grade = 1'b0;
        $display("test expire done");
    endtask
    task automatic t_mode();
        issue(CMD_REF, 2'h0, 13'h0000);
        issue(CMD_ACT, 2'h0, 13'h0000);
        check("rfc", gap >= RFC_F_CYC, 1'b1);
        issue(CMD_PRE, 2'h0, 13'h0000);
        issue(CMD_MRS, 2'h0, 13'h0032);
        check("mrs pins", pins, 4'h0);
        issue(CMD_REF, 2'h0, 13'h0000);
        check("mrd", gap >= MRD_CYC, 1'b1);
        issue(CMD_SRE, 2'h0, 13'h0000);
        @(negedge core_clk);
        check("sr cke", cke, 1'b0);
        check("in sr", in_self_refresh, 1'b1);
        issue(CMD_SRX, 2'h0, 13'h0000);
        check("srx cke", cke, 1'b1);
        t0 = last;
        issue(CMD_ACT, 2'h0, 13'h0000);
        check("xsnr", gap >= XSNR_CYC, 1'b1);
        issue(CMD_RD, 2'h0, 13'h0000);
        check("xsrd", last - t0 >= XSRD_CYC, 1'b1);
        issue(CMD_PRE, 2'h0, 13'h0000);
        $display("test mode done");
    endtask
    task automatic t_refresh();
        int n;
        int refs;
        extended_temp_automotive_grade = 1'b1;
        n = 0;
        while (refresh_due === 1'b1 && n < 20) begin
            issue(CMD_REF, 2'h0, 13'h0000);
            n++;
        end
        n = 0;
        while (refresh_due !== 1'b1 && n < 100) begin
            @(negedge core_clk);
            n++;
        end
        check("refi hot", n <= HOT_T + 1, 1'b1);
        // Left alone, a backlog reaching the urgent level must draw forced refreshes
        refs = 0;
        repeat (9 * HOT_T) begin
            @(negedge core_clk);
            if (pins === 4'h1 && cke === 1'b1) refs++;
        end
        check("forced ref", refs > 0, 1'b1);
        check("model viol", viol, 8'h00);
        $display("test refresh done");
    endtask
    task automatic test_done();
        $display("Counts: %0d compared, %0d bad", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #(25 * 20000);
        errors++;
        test_done();
    end
    initial begin
        repeat (20) @(negedge core_clk);
        check("rst pins", pins, 4'hf);
        check("rst cke", cke, 1'b0);
        check("rst oe", dqs_oe_n, 1'b1);
        rst = 1'b0;
        @(negedge core_clk);
        check("nop pins", pins, 4'h7);
        t_bank();
        t_write();
        t_expire();
        t_mode();
        t_refresh();
        test_done();
    end
endmodule
